// [rtl/sfps_defs.svh]
// Constants of the serial flash power-up state logic
// Overview of operation
// - Reset and power-up default to clock mode three
// - Data output stays off until a read
// - Commands start only after a select fall
// - Each select fall samples clock idle level
// - No command response while power-on reset
// - Power-on reset release enters standby state
// - Program or erase as first command waits until 3 ms after standby entry
// - Address bits split page, byte, dummy
`ifndef SFPS_DEFS_SVH
`define SFPS_DEFS_SVH
// Clock rate and times
`define SFPS_CLK_MHZ      250
`define SFPS_SEL_WAIT_US  70
`define SFPS_PUW_MS       3
`define SFPS_SEL_WAIT_CYC (`SFPS_SEL_WAIT_US * `SFPS_CLK_MHZ)
`define SFPS_PUW_CYC      (`SFPS_PUW_MS * 1000 * `SFPS_CLK_MHZ)
// Command word layout
`define SFPS_CMD_BITS     32
`define SFPS_OPC_MSB      31
`define SFPS_OPC_LSB      24
`define SFPS_DUMMY_MSB    23
`define SFPS_DUMMY_LSB    20
`define SFPS_PAGE_MSB     19
`define SFPS_PAGE_LSB     9
`define SFPS_BYTE_MSB     8
`define SFPS_BYTE_LSB     0
// Reset values
`define SFPS_MODE3_RST    1'b1
`define SFPS_TGL_RST      1'b0
`endif

// [rtl/sfps_pkg.sv]
// Types of the serial flash power-up state logic
`include "sfps_defs.svh"
package sfps_pkg;
	typedef enum logic [0:0] {
		SFPS_POR,
		SFPS_STANDBY
	} sfps_state_t;

	typedef struct packed {
		logic [7:0]  opcode;
		logic [10:0] page;
		logic [8:0]  byte_addr;
	} sfps_cmd_t;

	typedef struct packed {
		logic       sck;
		logic       cs_n;
		logic       si;
	} sfps_spi_t;
endpackage

// [rtl/sfps_link.sv]
// Link-clock command shifter of the serial flash power-up state logic
`timescale 1ns/10ps
`default_nettype none
`include "sfps_defs.svh"
module sfps_link (
	// Serial pins
	input  wire logic                       spi_sck_i,
	input  wire logic                       spi_cs_n_i,
	input  wire logic                       spi_si_i,
	// Command word toward the system clock
	output logic [`SFPS_CMD_BITS-1:0]       cmd_word_o,
	output logic                            cmd_tgl_o
);
	logic [`SFPS_CMD_BITS-2:0] shift_r;
	logic [5:0]                cnt_r;
	logic [`SFPS_CMD_BITS-1:0] word_r;
	logic                      tgl_r = `SFPS_TGL_RST; // Power-up level; no system reset reaches this domain

	// Frame state, cleared while select is high
	always_ff @(posedge spi_sck_i or posedge spi_cs_n_i) begin
		if (spi_cs_n_i) begin
			shift_r <= '0;
			cnt_r   <= 6'h00;
		end else begin
			shift_r <= {shift_r[`SFPS_CMD_BITS-3:0], spi_si_i};
			if (cnt_r != 6'h3f) begin
				cnt_r <= cnt_r + 6'h01;
			end
		end
	end

	// Word hand-over, held across frames; the toggle tells the system side
	always_ff @(posedge spi_sck_i) begin
		if (!spi_cs_n_i && cnt_r == 6'(`SFPS_CMD_BITS - 1)) begin
			word_r <= {shift_r, spi_si_i};
			tgl_r  <= ~tgl_r;
		end
	end

	// Outputs toward the system clock
	assign cmd_word_o = word_r;
	assign cmd_tgl_o  = tgl_r;
endmodule
`default_nettype wire

// [rtl/sfps_top.sv]
// Power-on and reset state logic of the serial flash interface
`timescale 1ns/10ps
`default_nettype none
`include "sfps_defs.svh"
module sfps_top #(
	parameter int SEL_WAIT_CYC = `SFPS_SEL_WAIT_CYC,
	parameter int PUW_CYC      = `SFPS_PUW_CYC
) (
	// System clock and reset
	input  wire logic              sys_clk_i,
	input  wire logic              sys_rst_i,
	// Supply monitor
	input  wire logic              supply_ok_i,
	// Serial pins
	input  wire logic              spi_sck_i,
	input  wire logic              spi_cs_n_i,
	input  wire logic              spi_si_i,
	output logic                   spi_so_o,
	output logic                   spi_so_oe_o,
	// Status
	output logic                   standby_o,
	output logic                   mode3_o,
	output logic                   early_access_o,
	output logic                   pe_pending_o,
	// Command result
	output logic                   cmd_valid_o,
	output sfps_pkg::sfps_cmd_t    cmd_o,
	output logic                   pe_start_o
);
	localparam int CW = 20;

	////////////////////////////////////////////////////////////////////////
	// Parameter checks
	if (SEL_WAIT_CYC < 1 || SEL_WAIT_CYC >= (1 << CW)) begin : g_chk_sel
		$error("SEL_WAIT_CYC out of range");
	end
	if (PUW_CYC < 1 || PUW_CYC >= (1 << CW)) begin : g_chk_puw
		$error("PUW_CYC out of range");
	end

	////////////////////////////////////////////////////////////////////////
	// Link-side shifter
	logic [`SFPS_CMD_BITS-1:0] link_word;
	logic                      link_tgl;

	sfps_link u_link (
		.spi_sck_i  (spi_sck_i),
		.spi_cs_n_i (spi_cs_n_i),
		.spi_si_i   (spi_si_i),
		.cmd_word_o (link_word),
		.cmd_tgl_o  (link_tgl)
	);

	////////////////////////////////////////////////////////////////////////
	// State
	typedef struct packed {
		sfps_pkg::sfps_state_t state;
		sfps_pkg::sfps_spi_t   pin_s1;
		sfps_pkg::sfps_spi_t   pin_s2;
		logic                  sup_s1;
		logic                  sup_s2;
		logic                  tgl_s1;
		logic                  tgl_s2;
		logic                  tgl_d;
		logic                  cs_d;
		logic                  mode3;
		logic                  frame_ok;
		logic [CW-1:0]         sel_cnt;
		logic                  sel_done;
		logic [CW-1:0]         puw_cnt;
		logic                  puw_done;
		logic                  first_seen;
		logic                  pe_pend;
		logic                  pe_start;
		logic                  early;
		logic                  cmd_vld;
		sfps_pkg::sfps_cmd_t   cmd;
		logic                  so_oe;
		logic                  standby;
	} sfps_regs_t;

	sfps_regs_t st_r;
	sfps_regs_t st_nxt;

	////////////////////////////////////////////////////////////////////////
	// Opcode classes
	function automatic logic sfps_is_read(input logic [7:0] op);
		case (op)
			8'h01, 8'h03, 8'h0B, 8'h1B, 8'hD1, 8'hD2, 8'hD3, 8'hD4, 8'hD6: sfps_is_read = 1'b1;
			default: sfps_is_read = 1'b0;
		endcase
	endfunction

	function automatic logic sfps_is_pe(input logic [7:0] op);
		case (op)
			8'h02, 8'h50, 8'h58, 8'h59, 8'h7C, 8'h81, 8'h82, 8'h83,
			8'h85, 8'h86, 8'h88, 8'h89: sfps_is_pe = 1'b1;
			default: sfps_is_pe = 1'b0;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Next-state logic
	logic       cs_fall;
	logic       cs_rise;
	logic       tgl_evt;
	logic [7:0] op;

	always_comb begin
		st_nxt   = st_r;
		cs_fall  = st_r.cs_d && !st_r.pin_s2.cs_n;
		cs_rise  = !st_r.cs_d && st_r.pin_s2.cs_n;
		tgl_evt  = st_r.tgl_s2 != st_r.tgl_d;
		op       = link_word[`SFPS_OPC_MSB:`SFPS_OPC_LSB];

		// Two-flop synchronisers
		st_nxt.pin_s1 = {spi_sck_i, spi_cs_n_i, spi_si_i};
		st_nxt.pin_s2 = st_r.pin_s1;
		st_nxt.sup_s1 = supply_ok_i;
		st_nxt.sup_s2 = st_r.sup_s1;
		st_nxt.tgl_s1 = link_tgl;
		st_nxt.tgl_s2 = st_r.tgl_s1;
		st_nxt.tgl_d  = st_r.tgl_s2;
		st_nxt.cs_d   = st_r.pin_s2.cs_n;

		st_nxt.cmd_vld  = 1'b0;
		st_nxt.pe_start = 1'b0;

		// Clock mode from idle clock level at each select fall
		if (cs_fall) begin
			st_nxt.mode3 = st_r.pin_s2.sck;
		end

		case (st_r.state)
			sfps_pkg::SFPS_POR: begin
				// Hold frames, output enable and timers off until the supply is good
				st_nxt.frame_ok = 1'b0;
				st_nxt.so_oe    = 1'b0;
				st_nxt.sel_cnt  = '0;
				st_nxt.puw_cnt  = '0;
				if (st_r.sup_s2) begin
					st_nxt.state = sfps_pkg::SFPS_STANDBY;
				end
			end
			sfps_pkg::SFPS_STANDBY: begin
				// Select wait and first-write delay timers
				if (!st_r.sel_done) begin
					st_nxt.sel_cnt  = st_r.sel_cnt + CW'(1);
					st_nxt.sel_done = (st_r.sel_cnt == CW'(SEL_WAIT_CYC - 1));
				end
				if (!st_r.puw_done) begin
					st_nxt.puw_cnt  = st_r.puw_cnt + CW'(1);
					st_nxt.puw_done = (st_r.puw_cnt == CW'(PUW_CYC - 1));
				end
				// Select fall opens a frame; early ones are flagged
				if (cs_fall) begin
					st_nxt.frame_ok = 1'b1;
					if (!st_r.sel_done) begin
						st_nxt.early = 1'b1;
					end
				end
				if (cs_rise) begin
					st_nxt.so_oe = 1'b0;
				end
				// Accept one command word per opened frame
				if (tgl_evt && st_r.frame_ok) begin
					st_nxt.frame_ok       = 1'b0;
					st_nxt.cmd.opcode     = op;
					st_nxt.cmd.page       = link_word[`SFPS_PAGE_MSB:`SFPS_PAGE_LSB];
					st_nxt.cmd.byte_addr  = link_word[`SFPS_BYTE_MSB:`SFPS_BYTE_LSB];
					st_nxt.cmd_vld        = 1'b1;
					st_nxt.first_seen     = 1'b1;
					if (sfps_is_read(op) && !st_r.pin_s2.cs_n) begin
						st_nxt.so_oe = 1'b1;
					end
					if (sfps_is_pe(op)) begin
						if (!st_r.first_seen && !st_r.puw_done) begin
							st_nxt.pe_pend = 1'b1;
						end else begin
							st_nxt.pe_start = 1'b1;
						end
					end
				end
				// Deferred first program or erase
				if (st_r.pe_pend && st_r.puw_done) begin
					st_nxt.pe_pend  = 1'b0;
					st_nxt.pe_start = 1'b1;
				end
				if (!st_r.sup_s2) begin
					st_nxt.state    = sfps_pkg::SFPS_POR;
					st_nxt.mode3    = `SFPS_MODE3_RST;
					st_nxt.sel_done = 1'b0;
					st_nxt.puw_done = 1'b0;
					st_nxt.first_seen = 1'b0;
					st_nxt.pe_pend  = 1'b0;
					st_nxt.so_oe    = 1'b0;
				end
			end
			default: begin
				st_nxt.state = sfps_pkg::SFPS_POR;
			end
		endcase
		// Standby flag kept in its own flop for the output
		st_nxt.standby = (st_nxt.state == sfps_pkg::SFPS_STANDBY);
	end

	////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			st_r          <= '0;
			st_r.state    <= sfps_pkg::SFPS_POR;
			st_r.pin_s1   <= 3'b010;
			st_r.pin_s2   <= 3'b010;
			st_r.cs_d     <= 1'b1;
			st_r.mode3    <= `SFPS_MODE3_RST;
		end else begin
			st_r          <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign spi_so_o       = 1'b0;
	assign spi_so_oe_o    = st_r.so_oe;
	assign standby_o      = st_r.standby;
	assign mode3_o        = st_r.mode3;
	assign early_access_o = st_r.early;
	assign pe_pending_o   = st_r.pe_pend;
	assign cmd_valid_o    = st_r.cmd_vld;
	assign cmd_o          = st_r.cmd;
	assign pe_start_o     = st_r.pe_start;
endmodule
`default_nettype wire

// [testbench/sfps_top_monitor.sv]
// Property checker of the serial flash power-up state logic
`timescale 1ns/10ps
`default_nettype none
module sfps_mon #(
	parameter int PUW_CYC = 50
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	// Pins and status
	input wire logic supply_ok_i,
	input wire logic spi_sck_i,
	input wire logic spi_cs_n_i,
	input wire logic spi_so_oe_o,
	input wire logic standby_o,
	input wire logic mode3_o,
	input wire logic pe_pending_o,
	input wire logic cmd_valid_o,
	input wire logic pe_start_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);
	int sb_cnt_r;
	// Cycles spent in standby
	always_ff @(posedge sys_clk_i) begin
		sb_cnt_r <= (standby_o && !sys_rst_i) ? sb_cnt_r + 1 : 0;
	end
	AST_RST_MODE3: assert property ($fell(sys_rst_i) |-> mode3_o) else $error("mode not 3 after reset");
	AST_OE_CMD: assert property ($rose(spi_so_oe_o) |-> cmd_valid_o) else $error("output on without command");
	AST_CS_LOW: assert property (cmd_valid_o |-> !$past(spi_cs_n_i, 4)) else $error("command outside frame");
	AST_MODE_SAMPLE: assert property ($fell(spi_cs_n_i) |-> ##5 (mode3_o == spi_sck_i)) else $error("mode wrong");
	AST_CMD_STBY: assert property (cmd_valid_o |-> standby_o) else $error("command taken in reset");
	AST_STBY_UP: assert property (supply_ok_i [*5] |-> standby_o) else $error("standby not entered");
	AST_PE_WAIT: assert property (pe_start_o |-> sb_cnt_r >= PUW_CYC) else $error("program started early");
	AST_PEND_START: assert property ($fell(pe_pending_o) && standby_o |-> pe_start_o) else $error("pending lost");
	// Main scenarios
	cover property (cmd_valid_o && pe_pending_o);
	cover property (pe_start_o && !cmd_valid_o);
	cover property (cmd_valid_o && !mode3_o);
	cover property ($fell(standby_o));
endmodule
`default_nettype wire

// [testbench/sfps_host.sv]
// Host model driving select, clock and serial input
`timescale 1ns/10ps
`default_nettype none
module sfps_host (
	// Serial pins toward the device
	output logic spi_sck_o,
	output logic spi_cs_n_o,
	output logic spi_si_o
);
	// Idle lines
	initial begin
		spi_sck_o = 1'b1;
		spi_cs_n_o = 1'b1;
		spi_si_o = 1'b0;
	end
	// One frame of n bits; the idle clock level picks the mode
	task automatic frame(input logic idle, input logic [31:0] w, input int n);
		spi_sck_o = idle;
		#101 spi_cs_n_o = 1'b0;
		#80;
		for (int i = 31; i > 31 - n; i--) begin
			spi_sck_o = 1'b0;
			spi_si_o = w[i];
			#80 spi_sck_o = 1'b1;
			#80;
		end
		spi_sck_o = idle;
		#40 spi_cs_n_o = 1'b1;
		spi_si_o = ~spi_si_o;
		#100;
	endtask
endmodule
`default_nettype wire

// [testbench/testbench.sv]
// Testbench of the serial flash power-up state logic
`timescale 1ns/10ps
`default_nettype none
module testbench;
	localparam int PUW = 2000;
	// Design pins
	logic                sys_clk_i;
	logic                sys_rst_i;
	logic                supply_ok_i;
	logic                spi_sck_i;
	logic                spi_cs_n_i;
	logic                spi_si_i;
	logic                spi_so_o;
	logic                spi_so_oe_o;
	logic                standby_o;
	logic                mode3_o;
	logic                early_access_o;
	logic                pe_pending_o;
	logic                cmd_valid_o;
	sfps_pkg::sfps_cmd_t cmd_o;
	logic                pe_start_o;
	int                  fails, tests_run, n_cmd, sb_cnt, pe_at, k;
	logic                oe_seen, pe_now;
	sfps_top #(
		.SEL_WAIT_CYC (100),
		.PUW_CYC      (PUW)
	) dut (
		.sys_clk_i      (sys_clk_i),
		.sys_rst_i      (sys_rst_i),
		.supply_ok_i    (supply_ok_i),
		.spi_sck_i      (spi_sck_i),
		.spi_cs_n_i     (spi_cs_n_i),
		.spi_si_i       (spi_si_i),
		.spi_so_o       (spi_so_o),
		.spi_so_oe_o    (spi_so_oe_o),
		.standby_o      (standby_o),
		.mode3_o        (mode3_o),
		.early_access_o (early_access_o),
		.pe_pending_o   (pe_pending_o),
		.cmd_valid_o    (cmd_valid_o),
		.cmd_o          (cmd_o),
		.pe_start_o     (pe_start_o)
	);
	sfps_host host (.spi_sck_o(spi_sck_i), .spi_cs_n_o(spi_cs_n_i), .spi_si_o(spi_si_i));
	// Clock
	initial sys_clk_i = 1'b0;
	always #2 sys_clk_i = ~sys_clk_i;
	// Record pulses and standby time
	always @(posedge sys_clk_i) begin
		if (cmd_valid_o === 1'b1) n_cmd++;
		if (spi_so_oe_o === 1'b1) oe_seen = 1'b1;
		if ((pe_start_o & cmd_valid_o) === 1'b1) pe_now = 1'b1;
		if (pe_start_o === 1'b1) pe_at = sb_cnt;
		sb_cnt = (standby_o === 1'b1) ? sb_cnt + 1 : 0;
	end
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic bound(input int lim);
		if (k >= lim) begin
			fails++;
			$display("ERROR timeout expected %0d seen %0d", lim, k);
			wrap_up();
		end
	endtask
	task automatic go(input logic idle, input logic [31:0] w, input int n);
		n_cmd = 0;
		oe_seen = 1'b0;
		pe_now = 1'b0;
		host.frame(idle, w, n);
		repeat (8) @(posedge sys_clk_i);
	endtask
	// Frame while the supply is still low
	task automatic t_por;
		chk("mode3", 1, mode3_o);
		chk("so_oe", 0, spi_so_oe_o);
		chk("so", 0, spi_so_o);
		go(1'b1, 32'h0300_1234, 32);
		chk("por_cmds", 0, n_cmd);
		chk("standby", 0, standby_o);
	endtask
	// Early first program waits for the start delay
	task automatic t_first_pe;
		supply_ok_i <= 1'b1;
		for (k = 0; k < 10 && standby_o !== 1'b1; k++) @(posedge sys_clk_i);
		bound(10);
		chk("standby", 1, standby_o);
		go(1'b1, 32'h82F5_5155, 32);
		chk("cmds", 1, n_cmd);
		chk("cmd", 32'h0825_5155, {4'h0, cmd_o});
		chk("early", 1, early_access_o);
		chk("pending", 1, pe_pending_o);
		chk("oe", 0, oe_seen);
		for (k = 0; k < 3000 && pe_pending_o !== 1'b0; k++) @(posedge sys_clk_i);
		bound(3000);
		@(posedge sys_clk_i);
		chk("pe_late", 1, pe_at >= PUW);
	endtask
	// Mode 0 read with dummy bits set
	task automatic t_read0;
		go(1'b0, 32'h03AF_FE01, 32);
		chk("mode3", 0, mode3_o);
		chk("oe", 1, oe_seen);
		chk("oe_off", 0, spi_so_oe_o);
		chk("cmd", 32'h003F_FE01, {4'h0, cmd_o});
	endtask
	// Short frame, then an erase after the delay
	task automatic t_short_pe;
		go(1'b1, 32'h0300_0000, 20);
		chk("short", 0, n_cmd);
		chk("mode3", 1, mode3_o);
		go(1'b1, 32'h8100_0200, 32);
		chk("pe_now", 1, pe_now);
	endtask
	// Supply loss falls back to power-on reset, then recovers
	task automatic t_drop;
		go(1'b0, 32'h0B00_0000, 32);
		chk("cmds", 1, n_cmd);
		chk("mode3", 0, mode3_o);
		chk("oe_off", 0, spi_so_oe_o);
		supply_ok_i <= 1'b0;
		repeat (6) @(posedge sys_clk_i);
		chk("standby", 0, standby_o);
		chk("mode3", 1, mode3_o);
		go(1'b1, 32'h8200_0000, 32);
		chk("por_cmds", 0, n_cmd);
		supply_ok_i <= 1'b1;
		for (k = 0; k < 10 && standby_o !== 1'b1; k++) @(posedge sys_clk_i);
		bound(10);
		chk("mode3", 1, mode3_o);
		chk("pending", 0, pe_pending_o);
	endtask
	// Main sequence
	initial begin
		sys_rst_i = 1'b1;
		supply_ok_i = 1'b0;
		fails = 0;
		tests_run = 0;
		repeat (5) @(posedge sys_clk_i);
		sys_rst_i <= 1'b0;
		repeat (2) @(posedge sys_clk_i);
		t_por();
		t_first_pe();
		t_read0();
		t_short_pe();
		t_drop();
		wrap_up();
	end
endmodule
bind sfps_top sfps_mon #(.PUW_CYC(PUW_CYC)) mon (
	.sys_clk_i    (sys_clk_i),
	.sys_rst_i    (sys_rst_i),
	.supply_ok_i  (supply_ok_i),
	.spi_sck_i    (spi_sck_i),
	.spi_cs_n_i   (spi_cs_n_i),
	.spi_so_oe_o  (spi_so_oe_o),
	.standby_o    (standby_o),
	.mode3_o      (mode3_o),
	.pe_pending_o (pe_pending_o),
	.cmd_valid_o  (cmd_valid_o),
	.pe_start_o   (pe_start_o)
);
`default_nettype wire
